// >>> hw/sdp_pkg.sv
// shared constants and types of the sdram pin command interface
package sdp_pkg;
	// clock and refresh timing
	localparam int MCLK_NS = 100;
	localparam int REF_WINDOW_MS = 64;
	localparam int REF_ROWS = 8192;
	localparam int SREF_CYC = (REF_WINDOW_MS * 1000000) / REF_ROWS / MCLK_NS;
	localparam int SREF_W = 7;
	localparam logic [SREF_W-1:0] SREF_LOAD = SREF_W'(SREF_CYC - 1);

	// organisation (16-bit part)
	localparam int NBANK = 4;
	localparam int NROW = 8192;
	localparam int NCOL = 512;
	localparam int DW = 16;
	localparam int AW = 13;
	localparam int CW = 9;
	localparam int BW = 2;
	localparam int MEM_AW = BW + AW + CW;
	localparam int AP_BIT = 10;

	// configuration register fields
	localparam int CFG_BL_LSB = 0;
	localparam int CFG_BT_BIT = 3;
	localparam int CFG_CL_LSB = 4;
	localparam logic [2:0] BL_1 = 3'h0;
	localparam logic [2:0] BL_2 = 3'h1;
	localparam logic [2:0] BL_4 = 3'h2;
	localparam logic [2:0] BL_8 = 3'h3;
	localparam logic [2:0] BL_FP = 3'h7;
	localparam logic [2:0] CL_2 = 3'h2;
	localparam logic [2:0] CL_3 = 3'h3;
	localparam logic [AW-1:0] MAIN_CFG_RST = 13'h0030;
	localparam logic [AW-1:0] EXT_CFG_RST = 13'h0000;

	typedef enum logic [3:0] {
		CMD_DESL = 4'h0,
		CMD_NOP = 4'h1,
		CMD_BST = 4'h2,
		CMD_RD = 4'h3,
		CMD_WR = 4'h4,
		CMD_ACT = 4'h5,
		CMD_PRE = 4'h6,
		CMD_REF = 4'h7,
		CMD_LOAD = 4'h8
	} sdp_cmd_t;

	typedef enum logic [4:0] {
		PS_RUN = 5'h01,
		PS_PDN = 5'h02,
		PS_SREF = 5'h04,
		PS_DPD = 5'h08,
		PS_SUSP = 5'h10
	} sdp_pwr_t;
endpackage

// >>> hw/sdp_cmd_decode.sv
// command decoder from the sampled strobe levels
`timescale 1ns/1ps
module sdp_cmd_decode (
	// strobes
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	// decoded command
	output sdp_pkg::sdp_cmd_t cmd
);
	import sdp_pkg::*;

	always_comb begin
		cmd = CMD_DESL;
		if (!cs_n) begin
			unique case ({ras_n, cas_n, we_n})
				3'h7: cmd = CMD_NOP;
				3'h6: cmd = CMD_BST;
				3'h5: cmd = CMD_RD;
				3'h4: cmd = CMD_WR;
				3'h3: cmd = CMD_ACT;
				3'h2: cmd = CMD_PRE;
				3'h1: cmd = CMD_REF;
				3'h0: cmd = CMD_LOAD;
			endcase
		end
	end
endmodule

// >>> hw/sdp_array.sv
// cell array: four banks of rows by columns, byte-lane write enables
`timescale 1ns/1ps
module sdp_array (
	// clock
	input wire logic mclk,
	// write port
	input wire logic wr_en,
	input wire logic [sdp_pkg::MEM_AW-1:0] wr_addr,
	input wire logic [sdp_pkg::DW-1:0] wr_data,
	input wire logic [1:0] wr_be,
	// read port
	input wire logic [sdp_pkg::MEM_AW-1:0] rd_addr,
	output logic [sdp_pkg::DW-1:0] rd_data
);
	import sdp_pkg::*;

	// no reset: cell contents are undefined after power-up
	logic [DW-1:0] mem [0:NBANK*NROW*NCOL-1];

	always_ff @(posedge mclk) begin
		if (wr_en && wr_be[0]) begin
			mem[wr_addr][7:0] <= wr_data[7:0];
		end
		if (wr_en && wr_be[1]) begin
			mem[wr_addr][15:8] <= wr_data[15:8];
		end
	end

	assign rd_data = mem[rd_addr];
endmodule

// >>> hw/sdp_device.sv
// device side of the sdram pin interface: decode, banks, bursts, power states
`timescale 1ns/1ps
//
// Function
// - all pins captured on rising clock only
// - each edge in run state steps burst counter and outputs
// - low clock enable gates clock by state
// - power-down: only clock enable watched, inputs off
// - chip select high masks every command
// - strobes with chip select form command
// - masked byte lane not written
// - read mask floats lane two clocks later
// - low mask bits 0-7, high 8-15
// - bank inputs pick one of four banks
// - bank inputs pick main or extended config
// - thirteen row bits, nine column bits
// - address bit 10 on access: auto precharge
// - address bit 10 on precharge: all banks
// - read latency two or three clocks
// - burst of 1, 2, 4, 8, page
// - burst order sequential or interleaved
// - auto refresh and self refresh supported
// - bank is 8192 rows, 512 columns, 16 bits
// - bank bit 1 low main, high extended
module sdp_device (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// command pins
	input wire logic clk_en,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic bank_sel0,
	input wire logic bank_sel1,
	input wire logic [sdp_pkg::AW-1:0] addr_bus,
	input wire logic byte_mask_low,
	input wire logic byte_mask_high,
	// data pins, split into in, out and per-lane enable
	input wire logic [sdp_pkg::DW-1:0] data_bus_in,
	output logic [sdp_pkg::DW-1:0] data_bus_out,
	output logic [1:0] data_bus_oe,
	// status
	output sdp_pkg::sdp_pwr_t pwr_state,
	output logic [sdp_pkg::NBANK-1:0] bank_open,
	output logic [sdp_pkg::AW-1:0] refresh_row,
	output logic [sdp_pkg::AW-1:0] main_cfg,
	output logic [sdp_pkg::AW-1:0] ext_cfg
);
	import sdp_pkg::*;

	typedef struct packed {
		sdp_pwr_t pstate;
		logic [AW-1:0] main_cfg;
		logic [AW-1:0] ext_cfg;
		logic [NBANK-1:0] bank_open;
		logic [NBANK-1:0][AW-1:0] rows;
		logic b_rd;
		logic b_wr;
		logic b_ap;
		logic [BW-1:0] b_bank;
		logic [CW-1:0] b_start;
		logic [CW:0] b_idx;
		logic [DW-1:0] pipe1;
		logic pipe1_v;
		logic [DW-1:0] out;
		logic [1:0] oe;
		logic [1:0] mask_p1;
		logic [SREF_W-1:0] sref_cnt;
		logic [AW-1:0] ref_row;
	} sdp_state_t;

	localparam sdp_state_t ST_RST = '{pstate: PS_RUN, main_cfg: MAIN_CFG_RST, ext_cfg: EXT_CFG_RST,
		sref_cnt: SREF_LOAD, default: '0};

	function automatic logic [CW:0] burst_words(input logic [2:0] bl);
		logic [CW:0] w;
		w = 10'h001;
		unique case (bl)
			BL_1: w = 10'h001;
			BL_2: w = 10'h002;
			BL_4: w = 10'h004;
			BL_8: w = 10'h008;
			BL_FP: w = 10'h200;
			default: w = 10'h001;
		endcase
		return w;
	endfunction

	// wraps inside the aligned block of the burst length
	function automatic logic [CW-1:0] burst_col(input logic [CW-1:0] st, input logic [CW:0] idx,
		input logic [2:0] bl, input logic inter);
		logic [CW-1:0] m;
		logic [CW-1:0] i9;
		m = CW'(burst_words(bl) - 10'h001);
		i9 = idx[CW-1:0];
		if (inter && bl != BL_FP) begin
			return (st & ~m) | ((st ^ i9) & m);
		end
		return (st & ~m) | (CW'(st + i9) & m);
	endfunction

	sdp_state_t s_q;
	sdp_state_t s_d;
	sdp_cmd_t cmd;
	logic [BW-1:0] bank;
	logic [1:0] mask_in;
	logic [2:0] bl;
	logic [2:0] cl;
	logic inter;
	logic [CW:0] blen;
	logic [CW:0] idx1;
	logic busy;
	logic all_idle;
	logic last_step;
	logic mem_we;
	logic [MEM_AW-1:0] mem_wa;
	logic [MEM_AW-1:0] mem_ra;
	logic [1:0] mem_be;
	logic [DW-1:0] mem_rd;

	sdp_cmd_decode u_dec (
		.cs_n(cs_n),
		.ras_n(ras_n),
		.cas_n(cas_n),
		.we_n(we_n),
		.cmd(cmd)
	);

	sdp_array u_arr (
		.mclk(mclk),
		.wr_en(mem_we),
		.wr_addr(mem_wa),
		.wr_data(data_bus_in),
		.wr_be(mem_be),
		.rd_addr(mem_ra),
		.rd_data(mem_rd)
	);

	assign bank = {bank_sel1, bank_sel0};
	assign mask_in = {byte_mask_high, byte_mask_low};
	assign bl = s_q.main_cfg[CFG_BL_LSB +: 3];
	assign cl = s_q.main_cfg[CFG_CL_LSB +: 3];
	assign inter = s_q.main_cfg[CFG_BT_BIT];
	assign blen = burst_words(bl);
	assign idx1 = CW'(1) + s_q.b_idx;
	assign busy = s_q.b_rd | s_q.b_wr;
	assign all_idle = s_q.bank_open == 4'h0;
	// full page bursts wrap and run until stopped
	assign last_step = busy && bl != BL_FP && idx1 == blen;
	assign mem_ra = {s_q.b_bank, s_q.rows[s_q.b_bank], burst_col(s_q.b_start, s_q.b_idx, bl, inter)};

	always_comb begin
		s_d = s_q;
		mem_we = 1'b0;
		mem_wa = mem_ra;
		mem_be = 2'h0;
		unique case (s_q.pstate)
			PS_RUN: begin
				// read pipe: one stage for latency two, two stages for three
				s_d.pipe1 = mem_rd;
				s_d.pipe1_v = s_q.b_rd;
				s_d.out = (cl == CL_2) ? mem_rd : s_q.pipe1;
				s_d.oe = {2{(cl == CL_2) ? s_q.b_rd : s_q.pipe1_v}} & ~s_q.mask_p1;
				s_d.mask_p1 = mask_in;
				if (busy) begin
					if (s_q.b_wr) begin
						mem_we = 1'b1;
						mem_be = ~mask_in;
					end
					s_d.b_idx = idx1;
					if (last_step) begin
						s_d.b_rd = 1'b0;
						s_d.b_wr = 1'b0;
						if (s_q.b_ap) begin
							s_d.bank_open[s_q.b_bank] = 1'b0;
						end
					end
				end
				unique case (cmd)
					CMD_DESL, CMD_NOP: begin
					end
					CMD_BST: begin
						s_d.b_rd = 1'b0;
						s_d.b_wr = 1'b0;
					end
					CMD_RD, CMD_WR: begin
						// access to a closed bank is illegal and dropped
						if (s_q.bank_open[bank]) begin
							s_d.b_bank = bank;
							s_d.b_start = addr_bus[CW-1:0];
							s_d.b_ap = addr_bus[AP_BIT];
							s_d.b_rd = cmd == CMD_RD;
							s_d.b_wr = cmd == CMD_WR;
							s_d.b_idx = (cmd == CMD_WR) ? 10'h001 : 10'h000;
							s_d.bank_open[bank] = 1'b1;
							if (cmd == CMD_WR) begin
								mem_we = 1'b1;
								mem_wa = {bank, s_q.rows[bank], addr_bus[CW-1:0]};
								mem_be = ~mask_in;
								if (blen == 10'h001) begin
									s_d.b_wr = 1'b0;
									s_d.bank_open[bank] = ~addr_bus[AP_BIT];
								end
							end
						end
					end
					CMD_ACT: begin
						s_d.bank_open[bank] = 1'b1;
						s_d.rows[bank] = addr_bus;
					end
					CMD_PRE: begin
						if (addr_bus[AP_BIT]) begin
							s_d.bank_open = 4'h0;
							s_d.b_rd = 1'b0;
							s_d.b_wr = 1'b0;
						end else begin
							s_d.bank_open[bank] = 1'b0;
							if (s_q.b_bank == bank) begin
								s_d.b_rd = 1'b0;
								s_d.b_wr = 1'b0;
							end
						end
					end
					CMD_REF: begin
						if (all_idle) begin
							s_d.ref_row = AW'(s_q.ref_row + 13'h0001);
						end
					end
					CMD_LOAD: begin
						if (!busy) begin
							if (bank_sel1) begin
								s_d.ext_cfg = addr_bus;
							end else begin
								s_d.main_cfg = addr_bus;
							end
						end
					end
				endcase
				s_d.sref_cnt = SREF_LOAD;
				if (!clk_en) begin
					if (s_d.b_rd || s_d.b_wr) begin
						s_d.pstate = PS_SUSP;
					end else if (all_idle && cmd == CMD_REF) begin
						s_d.pstate = PS_SREF;
					end else if (all_idle && cmd == CMD_BST) begin
						s_d.pstate = PS_DPD;
					end else begin
						s_d.pstate = PS_PDN;
					end
				end
			end
			PS_SUSP: begin
				// everything frozen, data pins keep their level
				if (clk_en) begin
					s_d.pstate = PS_RUN;
				end
			end
			PS_PDN, PS_DPD: begin
				// input buffers off: only the wake level is looked at
				s_d.oe = 2'h0;
				if (clk_en) begin
					s_d.pstate = PS_RUN;
				end
			end
			PS_SREF: begin
				s_d.oe = 2'h0;
				if (s_q.sref_cnt == '0) begin
					s_d.sref_cnt = SREF_LOAD;
					s_d.ref_row = AW'(s_q.ref_row + 13'h0001);
				end else begin
					s_d.sref_cnt = SREF_W'(s_q.sref_cnt - 7'h01);
				end
				if (clk_en) begin
					s_d.pstate = PS_RUN;
				end
			end
			default: s_d.pstate = PS_RUN;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= ST_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign data_bus_out = s_q.out;
	assign data_bus_oe = s_q.oe;
	assign pwr_state = s_q.pstate;
	assign bank_open = s_q.bank_open;
	assign refresh_row = s_q.ref_row;
	assign main_cfg = s_q.main_cfg;
	assign ext_cfg = s_q.ext_cfg;

	logic run;
	assign run = s_q.pstate == PS_RUN;

	a_cs_masks_cmd: assert property (@(posedge mclk) disable iff (!rst_n)
		(cs_n && run && !busy) |=> $stable(bank_open) && $stable(main_cfg) && $stable(ext_cfg))
		else $error("command taken with chip select high");
	a_mask_low_hiz: assert property (@(posedge mclk) disable iff (!rst_n)
		(run && byte_mask_low) ##1 run |=> !data_bus_oe[0])
		else $error("low lane driven two clocks after mask");
	a_mask_high_hiz: assert property (@(posedge mclk) disable iff (!rst_n)
		(run && byte_mask_high) ##1 run |=> !data_bus_oe[1])
		else $error("high lane driven two clocks after mask");
	a_drive_only_read: assert property (@(posedge mclk) disable iff (!rst_n)
		((|data_bus_oe) && $past(run) && $past(run, 2)) |-> ($past(s_q.b_rd) || $past(s_q.b_rd, 2)))
		else $error("data driven outside read");
	a_read_lat_two: assert property (@(posedge mclk) disable iff (!rst_n)
		(run && cmd == CMD_RD && bank_open[bank] && cl == CL_2 && mask_in == 2'h0) ##1 run
		|=> data_bus_oe == 2'h3)
		else $error("read data late at latency two");
	a_read_lat_three: assert property (@(posedge mclk) disable iff (!rst_n)
		(run && !busy && !s_q.pipe1_v && cmd == CMD_RD && bank_open[bank] && cl == CL_3 && mask_in == 2'h0)
		##1 (run && mask_in == 2'h0) |=> data_bus_oe == 2'h0 ##1 data_bus_oe == 2'h3)
		else $error("read data wrong at latency three");
	a_burst_four_len: assert property (@(posedge mclk) disable iff (!rst_n)
		(run && cmd == CMD_RD && bank_open[bank] && bl == BL_4) ##1 (run && cmd == CMD_NOP) [*4]
		|=> !s_q.b_rd)
		else $error("four word burst length wrong");
	a_auto_pre_close: assert property (@(posedge mclk) disable iff (!rst_n)
		(run && last_step && s_q.b_ap && cmd == CMD_NOP) |=> !bank_open[$past(s_q.b_bank)])
		else $error("bank left open after auto precharge");
	a_pre_all_banks: assert property (@(posedge mclk) disable iff (!rst_n)
		(run && cmd == CMD_PRE && addr_bus[AP_BIT]) |=> bank_open == 4'h0 && !busy)
		else $error("precharge all left a bank open");
	a_load_select: assert property (@(posedge mclk) disable iff (!rst_n)
		(run && !busy && cmd == CMD_LOAD && bank_sel1) |=> ext_cfg == $past(addr_bus) && $stable(main_cfg))
		else $error("extended config load wrong");
	a_write_masked: assert property (@(posedge mclk) disable iff (!rst_n)
		(run && cmd == CMD_WR && bank_open[bank] && byte_mask_low) |-> mem_we && !mem_be[0])
		else $error("masked low lane written");
	a_suspend_entry: assert property (@(posedge mclk) disable iff (!rst_n)
		(run && !clk_en && s_q.b_rd && !last_step && cmd == CMD_NOP) |=> pwr_state == PS_SUSP
		##1 $stable(data_bus_out))
		else $error("clock suspend not held");
	a_sref_entry: assert property (@(posedge mclk) disable iff (!rst_n)
		(run && !clk_en && cmd == CMD_REF && all_idle) |=> pwr_state == PS_SREF)
		else $error("self refresh not entered");
	a_pd_wake: assert property (@(posedge mclk) disable iff (!rst_n)
		(pwr_state == PS_PDN && clk_en) |=> run)
		else $error("power down not left");

	c_read_burst: cover property (@(posedge mclk) disable iff (!rst_n) run && cmd == CMD_RD ##3 (|data_bus_oe));
	c_write_burst: cover property (@(posedge mclk) disable iff (!rst_n) run && cmd == CMD_WR ##1 s_q.b_wr);
	c_self_refresh: cover property (@(posedge mclk) disable iff (!rst_n) pwr_state == PS_SREF ##1 $changed(refresh_row));
	c_suspend: cover property (@(posedge mclk) disable iff (!rst_n) pwr_state == PS_SUSP ##1 run);
endmodule

// >>> tb/sdp_ctl_model.sv
// controller-side model that drives the sdram pins one command per cycle
`timescale 1ns/1ps
module sdp_ctl_model (
	// clock
	input wire logic mclk,
	// command pins
	output logic clk_en,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic bank_sel0,
	output logic bank_sel1,
	output logic [sdp_pkg::AW-1:0] addr_bus,
	output logic byte_mask_low,
	output logic byte_mask_high,
	// write data and its drive enable
	output logic [sdp_pkg::DW-1:0] wdata,
	output logic wdrive
);
	import sdp_pkg::*;
	initial begin
		{clk_en, cs_n, ras_n, cas_n, we_n} = 5'h1f;
		{bank_sel1, bank_sel0, byte_mask_high, byte_mask_low, wdrive} = 5'h00;
		addr_bus = 13'h0000;
		wdata = 16'h0000;
	end
	// launched just after an edge, so it is sampled at the following edge
	task automatic do_cmd(sdp_cmd_t c, logic [1:0] b = 2'h0, logic [12:0] a = 13'h0000,
		logic [15:0] d = 16'h0000, logic [1:0] m = 2'h0, logic drv = 1'b0, logic ce = 1'b1);
		logic [3:0] s;
		case (c)
			CMD_DESL: s = 4'h8;
			CMD_BST: s = 4'h6;
			CMD_RD: s = 4'h5;
			CMD_WR: s = 4'h4;
			CMD_ACT: s = 4'h3;
			CMD_PRE: s = 4'h2;
			CMD_REF: s = 4'h1;
			CMD_LOAD: s = 4'h0;
			default: s = 4'h7;
		endcase
		@(posedge mclk);
		{cs_n, ras_n, cas_n, we_n} <= s;
		{bank_sel1, bank_sel0} <= b;
		addr_bus <= a;
		{byte_mask_high, byte_mask_low} <= m;
		clk_en <= ce;
		wdrive <= drv;
		// released bus shows the inverse, not a stale copy
		wdata <= drv ? d : ~wdata;
		#1;
	endtask
endmodule

// >>> tb/tb_sdram_pin_command_interface.sv
// testbench of the sdram pin command interface against a controller model
`timescale 1ns/1ps
module tb_sdram_pin_command_interface;
	import sdp_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en, cs_n, ras_n, cas_n, we_n, bank_sel0, bank_sel1, byte_mask_low, byte_mask_high, wdrive;
	logic [AW-1:0] addr_bus, refresh_row, main_cfg, ext_cfg;
	logic [DW-1:0] wdata, dout, dq;
	logic [1:0] oe;
	logic [NBANK-1:0] bank_open;
	sdp_pwr_t pwr_state;
	int failures = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic [15:0] pa [4] = '{16'h22a0, 16'h11a1, 16'h22a2, 16'h22a3};
	always #50 mclk = ~mclk;
	// wire level from the device's per-lane enables, controller data otherwise
	assign dq = {oe[1] ? dout[15:8] : wdata[15:8], oe[0] ? dout[7:0] : wdata[7:0]};
	sdp_ctl_model i_ctl (.mclk(mclk), .clk_en(clk_en), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
		.we_n(we_n), .bank_sel0(bank_sel0), .bank_sel1(bank_sel1), .addr_bus(addr_bus),
		.byte_mask_low(byte_mask_low), .byte_mask_high(byte_mask_high), .wdata(wdata), .wdrive(wdrive));
	sdp_device i_dut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .bank_sel0(bank_sel0), .bank_sel1(bank_sel1), .addr_bus(addr_bus),
		.byte_mask_low(byte_mask_low), .byte_mask_high(byte_mask_high), .data_bus_in(dq),
		.data_bus_out(dout), .data_bus_oe(oe), .pwr_state(pwr_state), .bank_open(bank_open),
		.refresh_row(refresh_row), .main_cfg(main_cfg), .ext_cfg(ext_cfg));
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			tally_and_finish();
		end
	end
	always @(negedge mclk) begin
		if (rst_n && (oe & {2{wdrive}}) != 2'h0) begin
			failures++;
			$display("mismatch bus contention expected 0 seen %h", oe);
		end
	end
	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic nops(int n);
		repeat (n) i_ctl.do_cmd(CMD_NOP);
	endtask
	task automatic load(logic [1:0] b, logic [12:0] a);
		i_ctl.do_cmd(CMD_LOAD, b, a);
		nops(2);
	endtask
	task automatic wr4(logic [12:0] a, logic [15:0] base, logic [1:0] m1);
		for (int k = 0; k < 4; k++) begin
			i_ctl.do_cmd(k == 0 ? CMD_WR : CMD_NOP, 2'h1, a, base + 16'(k), k == 1 ? m1 : 2'h0, 1'b1);
		end
		nops(2);
	endtask
	// mask sampled one edge after the read, so it hits word 3-cl
	task automatic rd4(logic [12:0] a, int cl, int xr, logic [1:0] m);
		int idx;
		logic [15:0] msk;
		i_ctl.do_cmd(CMD_RD, 2'h1, a);
		i_ctl.do_cmd(CMD_NOP, 2'h0, 13'h0000, 16'h0000, m);
		nops(cl - 2);
		chk("oe before latency", 16'h0000, 16'(oe));
		for (int k = 0; k < 4; k++) begin
			nops(1);
			idx = xr != 0 ? (int'(a[1:0]) ^ k) : (int'(a[1:0]) + k) % 4;
			msk = k == 3 - cl ? {{8{~m[1]}}, {8{~m[0]}}} : 16'hffff;
			chk("lane oe", 16'(msk[8] ? 2'h3 & {msk[8], msk[0]} : {1'b0, msk[0]}), 16'(oe));
			chk("read word", pa[idx] & msk, dq & msk);
		end
		nops(1);
		chk("oe after burst", 16'h0000, 16'(oe));
	endtask
	task automatic t_cfg();
		chk("pwr_state", 16'(PS_RUN), 16'(pwr_state));
		chk("main_cfg", 16'(MAIN_CFG_RST), 16'(main_cfg));
		chk("ext_cfg", 16'(EXT_CFG_RST), 16'(ext_cfg));
		i_ctl.do_cmd(CMD_DESL, 2'h2, 13'h0155);
		nops(1);
		chk("ext_cfg", 16'(EXT_CFG_RST), 16'(ext_cfg));
		load(2'h2, 13'h0155);
		chk("ext_cfg", 16'h0155, 16'(ext_cfg));
		load(2'h1, 13'h0022);
		chk("main_cfg", 16'h0022, 16'(main_cfg));
	endtask
	task automatic t_banks();
		for (int i = 0; i < 4; i++) begin
			i_ctl.do_cmd(CMD_ACT, 2'(i), 13'h1fff);
			nops(1);
			chk("bank_open", 16'((1 << (i + 1)) - 1), 16'(bank_open));
		end
		i_ctl.do_cmd(CMD_PRE, 2'h2);
		nops(1);
		chk("bank_open", 16'h000b, 16'(bank_open));
		i_ctl.do_cmd(CMD_PRE, 2'h2, 13'h0400);
		nops(1);
		chk("bank_open", 16'h0000, 16'(bank_open));
	endtask
	task automatic t_data();
		i_ctl.do_cmd(CMD_ACT, 2'h1, 13'h0005);
		nops(1);
		wr4(13'h0004, 16'h1100, 2'h0);
		wr4(13'h0004, 16'h22a0, 2'h2);
		rd4(13'h0006, 2, 0, 2'h1);
		load(2'h0, 13'h003a);
		rd4(13'h0005, 3, 1, 2'h2);
		// written columns only, so frozen data is never unknown
		i_ctl.do_cmd(CMD_RD, 2'h1, 13'h0004);
		nops(2);
		i_ctl.do_cmd(CMD_NOP, 2'h0, 13'h0000, 16'h0000, 2'h0, 1'b0, 1'b0);
		nops(1);
		chk("pwr_state", 16'(PS_SUSP), 16'(pwr_state));
		nops(1);
		chk("pwr_state", 16'(PS_RUN), 16'(pwr_state));
		nops(6);
	endtask
	task automatic t_bursts();
		logic [2:0] code [5] = '{BL_1, BL_2, BL_4, BL_8, BL_FP};
		int n_exp [5] = '{1, 2, 4, 8, 11};
		int n;
		for (int j = 0; j < 5; j++) begin
			load(2'h0, 13'({4'h2, 1'b0, code[j]}));
			i_ctl.do_cmd(CMD_RD, 2'h1, 13'h0000);
			n = 0;
			repeat (12) begin
				nops(1);
				n += oe === 2'h3 ? 1 : 0;
			end
			chk("burst words", 16'(n_exp[j]), 16'(n));
			i_ctl.do_cmd(CMD_BST);
			nops(2);
		end
		load(2'h0, 13'h0020);
		i_ctl.do_cmd(CMD_RD, 2'h1, 13'h0400);
		nops(4);
		chk("bank_open", 16'h0000, 16'(bank_open));
	endtask
	task automatic t_power();
		logic [12:0] r;
		i_ctl.do_cmd(CMD_NOP, 2'h0, 13'h0000, 16'h0000, 2'h0, 1'b0, 1'b0);
		i_ctl.do_cmd(CMD_ACT, 2'h0, 13'h0000, 16'h0000, 2'h0, 1'b0, 1'b0);
		chk("pwr_state", 16'(PS_PDN), 16'(pwr_state));
		nops(2);
		chk("pwr_state", 16'(PS_RUN), 16'(pwr_state));
		chk("bank_open", 16'h0000, 16'(bank_open));
		r = refresh_row;
		i_ctl.do_cmd(CMD_REF, 2'h0, 13'h0000, 16'h0000, 2'h0, 1'b0, 1'b0);
		repeat (80) i_ctl.do_cmd(CMD_NOP, 2'h0, 13'h0000, 16'h0000, 2'h0, 1'b0, 1'b0);
		chk("pwr_state", 16'(PS_SREF), 16'(pwr_state));
		// entry refresh plus one timed refresh inside 80 clocks
		chk("refresh_row", 16'(r + 13'h0002), 16'(refresh_row));
		nops(2);
		r = refresh_row;
		i_ctl.do_cmd(CMD_REF);
		nops(1);
		chk("refresh_row", 16'(r + 13'h0001), 16'(refresh_row));
		i_ctl.do_cmd(CMD_BST, 2'h0, 13'h0000, 16'h0000, 2'h0, 1'b0, 1'b0);
		i_ctl.do_cmd(CMD_NOP, 2'h0, 13'h0000, 16'h0000, 2'h0, 1'b0, 1'b0);
		chk("pwr_state", 16'(PS_DPD), 16'(pwr_state));
		nops(3);
	endtask
	initial begin
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		nops(1);
		chk("data_bus_oe", 16'h0000, 16'(oe));
		t_cfg();
		t_banks();
		t_data();
		t_bursts();
		t_power();
		tally_and_finish();
	end
endmodule
